/* tdq_queue_mgr.sv */
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "tdq_map.svh"

// How it works
// - Descriptor address is base plus sixteen times reference.
// - Free cache holds six, written out one word at a time.
// - Completion-flagged descriptor flushes cache to free ring.
// - Rings located from queue base plus offsets.
// - Read marks last consumed; write marks next slot.
// - The end offset slot is never used.
// - Empty when read is just below write.
// - Full when read equals write; no writes.
// - Entry: 14-bit reference plus three status bits.
// - Free ring words have bits 31..17 zero.
// - No access to descriptor after its return.
// - Status codes: last, partial, unprovisioned, malformed.
// - Underflow flagged once, on first returned reference.
// - Late underflow reported on next packet's reference.
// - Only unprovisioned returns may head descriptor trees.
// - Two context entries per channel, 32 channels.
// - Context entry is four words of fields.
// - Chains sorted into per-channel lists via context.
// - New packet from high list unless empty.
// - Byte count decrements per access; zero means done.
// - Underflow flag set on indication, cleared on return.
module tdq_queue_mgr #(
    parameter int CHANNELS = 32,
    parameter int CACHE_DEPTH = 6
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [11:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    output logic o_mem_req,
    output logic o_mem_we,
    output logic [31:0] o_mem_addr,
    output logic [31:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [31:0] i_mem_rdata,
    output logic o_fetch_valid,
    output tdq_pkg::tdq_ref_t o_fetch_ref,
    output logic [31:0] o_fetch_addr,
    input wire logic i_fetch_ready,
    input wire tdq_pkg::tdq_op_t i_ctx_op,
    input wire tdq_pkg::tdq_ch_t i_ctx_ch,
    input wire logic i_ctx_pri,
    input wire tdq_pkg::tdq_ref_t i_ctx_ref,
    input wire tdq_pkg::tdq_ref_t i_ctx_host,
    input wire logic i_ctx_m,
    input wire logic i_ctx_ce,
    input wire logic i_ctx_abrt,
    input wire logic i_ctx_ioc,
    input wire logic [15:0] i_ctx_bytes,
    input wire logic [31:0] i_ctx_buf_addr,
    output logic o_sel_valid,
    output logic o_sel_hit,
    output logic o_sel_pri,
    output tdq_pkg::tdq_ref_t o_sel_ref,
    output logic [31:0] o_sel_addr,
    output logic o_acc_done,
    input wire logic i_uflow_valid,
    input wire tdq_pkg::tdq_ch_t i_uflow_ch,
    input wire logic i_uflow_pri,
    input wire logic i_done_valid,
    output logic o_done_ready,
    input wire tdq_pkg::tdq_ch_t i_done_ch,
    input wire logic i_done_pri,
    input wire tdq_pkg::tdq_ref_t i_done_ref,
    input wire tdq_pkg::tdq_status_t i_done_status,
    input wire logic i_done_ioc
);
    import tdq_pkg::*;

    localparam int CTX_ENTRIES = 2 * CHANNELS;

    if (CHANNELS < 1 || CHANNELS > 32)
        $error("CHANNELS must be 1 to 32");
    if (CACHE_DEPTH < 1 || CACHE_DEPTH > 15)
        $error("CACHE_DEPTH must be 1 to 15");

    // ======================================================================
    // Address arithmetic
    function automatic logic [31:0] desc_addr(input logic [31:0] base, input tdq_ref_t r);
        desc_addr = {base[31:4], 4'h0} + {14'h0, r, 4'h0};
    endfunction

    function automatic logic [31:0] ring_addr(input logic [31:0] base, input logic [15:0] off);
        ring_addr = {base[31:2], 2'h0} + {14'h0, off, 2'h0};
    endfunction

    // The end slot is skipped: stepping onto end wraps to start.
    function automatic logic [15:0] ring_next(input logic [15:0] cur, input logic [15:0] s,
                                              input logic [15:0] e);
        ring_next = (cur + 16'h1 == e) ? s : cur + 16'h1;
    endfunction

    function automatic logic ring_empty(input logic [15:0] r, input logic [15:0] w,
                                        input logic [15:0] s, input logic [15:0] e);
        ring_empty = (r + 16'h1 == w) || (r + 16'h1 == e && w == s);
    endfunction

    // ======================================================================
    // Software registers
    logic [31:0] ctrl_r;
    logic [31:0] desc_base_r;
    logic [31:0] queue_base_r;
    logic [15:0] rdy_start_r;
    logic [15:0] rdy_write_r;
    logic [15:0] rdy_read_r;
    logic [15:0] rdy_end_r;
    logic [15:0] free_start_r;
    logic [15:0] free_write_r;
    logic [15:0] free_read_r;
    logic [15:0] free_end_r;
    tdq_state_t state_r;
    logic fetch_valid_r;
    logic flush_r;
    logic [3:0] cache_cnt_r;
    logic [16:0] cache_mem [CACHE_DEPTH];
    logic [31:0] ctx_w0 [CTX_ENTRIES];
    logic [31:0] ctx_w1 [CTX_ENTRIES];
    logic [31:0] ctx_w2 [CTX_ENTRIES];
    logic [31:0] ctx_w3 [CTX_ENTRIES];
    logic [CTX_ENTRIES-1:0] ctx_u;

    logic rdy_empty;
    logic free_full;
    logic fetch_ack;
    logic flush_ack;
    logic push;
    logic [5:0] cidx;
    logic [5:0] didx;
    logic [5:0] uidx;
    logic [5:0] sidx;

    assign rdy_empty = ring_empty(rdy_read_r, rdy_write_r, rdy_start_r, rdy_end_r);
    assign free_full = (free_read_r == free_write_r);
    assign fetch_ack = (state_r == TDQ_ST_FETCH) && i_mem_ack;
    assign flush_ack = (state_r == TDQ_ST_FLUSH) && i_mem_ack;
    assign o_done_ready = !flush_r && (cache_cnt_r < 4'(CACHE_DEPTH));
    assign push = i_done_valid && o_done_ready;
    assign cidx = {i_ctx_ch, i_ctx_pri};
    assign didx = {i_done_ch, i_done_pri};
    assign uidx = {i_uflow_ch, i_uflow_pri};
    assign sidx = {i_ctx_ch, ctx_w0[{i_ctx_ch, 1'b1}][`TDQ_CTX_D_BIT]};
    assign o_fetch_valid = fetch_valid_r;

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ctrl_r <= `TDQ_RST_WORD;
            desc_base_r <= `TDQ_RST_WORD;
            queue_base_r <= `TDQ_RST_WORD;
            rdy_start_r <= `TDQ_RST_OFF;
            rdy_write_r <= `TDQ_RST_OFF;
            rdy_end_r <= `TDQ_RST_OFF;
            free_start_r <= `TDQ_RST_OFF;
            free_read_r <= `TDQ_RST_OFF;
            free_end_r <= `TDQ_RST_OFF;
        end
        else if (i_wr)
        begin
            unique case (i_addr)
                `TDQ_OFF_CTRL: ctrl_r <= {30'h0, i_wdata[1:0]};
                `TDQ_OFF_DESC_BASE: desc_base_r <= {i_wdata[31:4], 4'h0};
                `TDQ_OFF_QUEUE_BASE: queue_base_r <= {i_wdata[31:2], 2'h0};
                `TDQ_OFF_RDY_START: rdy_start_r <= i_wdata[15:0];
                `TDQ_OFF_RDY_WRITE: rdy_write_r <= i_wdata[15:0];
                `TDQ_OFF_RDY_END: rdy_end_r <= i_wdata[15:0];
                `TDQ_OFF_FREE_START: free_start_r <= i_wdata[15:0];
                `TDQ_OFF_FREE_READ: free_read_r <= i_wdata[15:0];
                `TDQ_OFF_FREE_END: free_end_r <= i_wdata[15:0];
                default: ;
            endcase
        end
    end

    // Offsets the engine moves itself; an engine update beats a software write.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            rdy_read_r <= `TDQ_RST_OFF;
            free_write_r <= `TDQ_RST_OFF;
        end
        else
        begin
            if (fetch_ack)
                rdy_read_r <= ring_next(rdy_read_r, rdy_start_r, rdy_end_r);
            else if (i_wr && i_addr == `TDQ_OFF_RDY_READ)
                rdy_read_r <= i_wdata[15:0];
            if (flush_ack)
                free_write_r <= ring_next(free_write_r, free_start_r, free_end_r);
            else if (i_wr && i_addr == `TDQ_OFF_FREE_WRITE)
                free_write_r <= i_wdata[15:0];
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_rdata <= `TDQ_RST_WORD;
        else if (!i_rd)
            o_rdata <= `TDQ_RST_WORD;
        else if (i_addr[`TDQ_CTX_WINDOW_BIT])
        begin
            unique case (i_addr[3:2])
                2'h0: o_rdata <= ctx_w0[i_addr[9:4]];
                2'h1: o_rdata <= ctx_w1[i_addr[9:4]];
                2'h2: o_rdata <= ctx_w2[i_addr[9:4]];
                2'h3: o_rdata <= ctx_w3[i_addr[9:4]] | {15'h0, ctx_u[i_addr[9:4]], 16'h0};
            endcase
        end
        else
        begin
            unique case (i_addr)
                `TDQ_OFF_CTRL: o_rdata <= ctrl_r;
                `TDQ_OFF_STATUS: o_rdata <= {23'h0, fetch_valid_r, flush_r, state_r, cache_cnt_r};
                `TDQ_OFF_DESC_BASE: o_rdata <= desc_base_r;
                `TDQ_OFF_QUEUE_BASE: o_rdata <= queue_base_r;
                `TDQ_OFF_RDY_START: o_rdata <= {16'h0, rdy_start_r};
                `TDQ_OFF_RDY_WRITE: o_rdata <= {16'h0, rdy_write_r};
                `TDQ_OFF_RDY_READ: o_rdata <= {16'h0, rdy_read_r};
                `TDQ_OFF_RDY_END: o_rdata <= {16'h0, rdy_end_r};
                `TDQ_OFF_FREE_START: o_rdata <= {16'h0, free_start_r};
                `TDQ_OFF_FREE_WRITE: o_rdata <= {16'h0, free_write_r};
                `TDQ_OFF_FREE_READ: o_rdata <= {16'h0, free_read_r};
                `TDQ_OFF_FREE_END: o_rdata <= {16'h0, free_end_r};
                default: o_rdata <= `TDQ_RST_WORD;
            endcase
        end
    end

    // ======================================================================
    // Host memory master: flushing the free cache beats fetching.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_r <= TDQ_ST_IDLE;
            o_mem_req <= 1'b0;
            o_mem_we <= 1'b0;
            o_mem_addr <= `TDQ_RST_WORD;
            o_mem_wdata <= `TDQ_RST_WORD;
        end
        else
        begin
            unique case (state_r)
                TDQ_ST_IDLE:
                begin
                    if (flush_r && cache_cnt_r != 4'h0 && !free_full)
                    begin
                        state_r <= TDQ_ST_FLUSH;
                        o_mem_req <= 1'b1;
                        o_mem_we <= 1'b1;
                        o_mem_addr <= ring_addr(queue_base_r, free_write_r);
                        o_mem_wdata <= {15'h0, cache_mem[0]};
                    end
                    else if (ctrl_r[`TDQ_CTRL_FETCH_EN] && !fetch_valid_r && !rdy_empty)
                    begin
                        state_r <= TDQ_ST_FETCH;
                        o_mem_req <= 1'b1;
                        o_mem_we <= 1'b0;
                        o_mem_addr <= ring_addr(queue_base_r,
                            ring_next(rdy_read_r, rdy_start_r, rdy_end_r));
                    end
                end
                TDQ_ST_FETCH, TDQ_ST_FLUSH:
                begin
                    if (i_mem_ack)
                    begin
                        state_r <= TDQ_ST_IDLE;
                        o_mem_req <= 1'b0;
                        o_mem_we <= 1'b0;
                    end
                end
                default: state_r <= TDQ_ST_IDLE;
            endcase
        end
    end

    // Only the low 14 bits of a ready entry name a descriptor.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            fetch_valid_r <= 1'b0;
            o_fetch_ref <= '0;
            o_fetch_addr <= `TDQ_RST_WORD;
        end
        else if (fetch_ack)
        begin
            fetch_valid_r <= 1'b1;
            o_fetch_ref <= i_mem_rdata[13:0];
            o_fetch_addr <= desc_addr(desc_base_r, i_mem_rdata[13:0]);
        end
        else if (i_fetch_ready)
            fetch_valid_r <= 1'b0;
    end

    // ======================================================================
    // Free cache. A pushed reference is final: nothing here reads its
    // descriptor again, so the engine never touches it after return.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            cache_cnt_r <= 4'h0;
            flush_r <= 1'b0;
            for (int k = 0; k < CACHE_DEPTH; k++)
                cache_mem[k] <= 17'h0;
        end
        else
        begin
            for (int k = 0; k < CACHE_DEPTH; k++)
            begin
                if (flush_ack && k < CACHE_DEPTH - 1)
                    cache_mem[k] <= cache_mem[(k + 1) % CACHE_DEPTH];
                else if (push && 4'(k) == cache_cnt_r)
                    cache_mem[k] <= {ctx_u[didx], i_done_status, i_done_ref};
            end
            if (push)
                cache_cnt_r <= cache_cnt_r + 4'h1;
            else if (flush_ack)
                cache_cnt_r <= cache_cnt_r - 4'h1;
            if (push && (!ctrl_r[`TDQ_CTRL_CACHE_EN] || i_done_ioc
                         || cache_cnt_r + 4'h1 == 4'(CACHE_DEPTH)))
                flush_r <= 1'b1;
            // The drain end is tested before the re-arm: with the cache off, the last
            // acknowledge would otherwise re-arm the flush and block pushes.
            else if (flush_ack && cache_cnt_r == 4'h1)
                flush_r <= 1'b0;
            else if (!ctrl_r[`TDQ_CTRL_CACHE_EN] && cache_cnt_r != 4'h0)
                flush_r <= 1'b1;
        end
    end

    // Underflow is caught into the entry's flag and handed out on the next
    // return; an indication in the same cycle as a return survives it.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
            ctx_u <= '0;
        else
        begin
            for (int k = 0; k < CTX_ENTRIES; k++)
            begin
                if (i_uflow_valid && 6'(k) == uidx)
                    ctx_u[k] <= 1'b1;
                else if (push && 6'(k) == didx)
                    ctx_u[k] <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Channel context table.
    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            for (int k = 0; k < CTX_ENTRIES; k++)
            begin
                ctx_w0[k] <= `TDQ_RST_WORD;
                ctx_w1[k] <= `TDQ_RST_WORD;
                ctx_w2[k] <= `TDQ_RST_WORD;
                ctx_w3[k] <= `TDQ_RST_WORD;
            end
        end
        else
        begin
            unique case (i_ctx_op)
                TDQ_OP_LINK:
                begin
                    if (!ctx_w0[cidx][`TDQ_CTX_D_BIT])
                    begin
                        ctx_w0[cidx] <= {i_ctx_m, i_ctx_ce, ctx_w0[cidx][29:16],
                                         2'h3, i_ctx_ref};
                        ctx_w1[cidx] <= {i_ctx_bytes, i_ctx_abrt, i_ctx_ioc, i_ctx_host};
                        ctx_w2[cidx] <= i_ctx_buf_addr;
                        ctx_w3[cidx][`TDQ_CTX_NA_BIT] <= (i_ctx_bytes == 16'h0);
                    end
                    else
                    begin
                        ctx_w0[cidx][29:16] <= i_ctx_ref;
                        if (!ctx_w3[cidx][`TDQ_CTX_V_BIT])
                        begin
                            ctx_w3[cidx][13:0] <= i_ctx_ref;
                            ctx_w3[cidx][`TDQ_CTX_V_BIT] <= 1'b1;
                        end
                    end
                end
                TDQ_OP_SELECT:
                begin
                    if (ctx_w0[sidx][`TDQ_CTX_D_BIT])
                        ctx_w3[sidx][`TDQ_CTX_PIP_BIT] <= 1'b1;
                end
                TDQ_OP_ACCESS:
                begin
                    if (ctx_w1[cidx][31:16] != 16'h0)
                    begin
                        ctx_w1[cidx][31:16] <= ctx_w1[cidx][31:16] - 16'h1;
                        ctx_w2[cidx] <= ctx_w2[cidx] + 32'h4;
                    end
                end
                TDQ_OP_ADVANCE:
                begin
                    ctx_w3[cidx][`TDQ_CTX_PIP_BIT] <= 1'b0;
                    if (ctx_w3[cidx][`TDQ_CTX_V_BIT])
                    begin
                        ctx_w0[cidx][13:0] <= ctx_w3[cidx][13:0];
                        ctx_w3[cidx][`TDQ_CTX_V_BIT] <= 1'b0;
                    end
                    else
                        ctx_w0[cidx][`TDQ_CTX_D_BIT] <= 1'b0;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_sel_valid <= 1'b0;
            o_sel_hit <= 1'b0;
            o_sel_pri <= 1'b0;
            o_sel_ref <= '0;
            o_sel_addr <= `TDQ_RST_WORD;
            o_acc_done <= 1'b0;
        end
        else
        begin
            o_sel_valid <= (i_ctx_op == TDQ_OP_SELECT);
            o_acc_done <= (i_ctx_op == TDQ_OP_ACCESS) && (ctx_w1[cidx][31:16] == 16'h1);
            if (i_ctx_op == TDQ_OP_SELECT)
            begin
                o_sel_hit <= ctx_w0[sidx][`TDQ_CTX_D_BIT];
                o_sel_pri <= sidx[0];
                o_sel_ref <= ctx_w0[sidx][13:0];
                o_sel_addr <= desc_addr(desc_base_r, ctx_w0[sidx][13:0]);
            end
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    fetch_addr_a: assert property ($rose(fetch_valid_r) && $stable(desc_base_r) |->
        o_fetch_addr - desc_base_r == {14'h0, o_fetch_ref, 4'h0})
        else $error("descriptor address not base plus 16 times reference");
    cache_bound_a: assert property (cache_cnt_r <= 4'(CACHE_DEPTH))
        else $error("free cache overfilled");
    ioc_flush_a: assert property (push && i_done_ioc |=> flush_r)
        else $error("completion flag did not start a flush");
    free_word_a: assert property (o_mem_req && o_mem_we |-> o_mem_wdata[31:17] == 15'h0)
        else $error("free ring word has nonzero upper bits");
    no_full_write_a: assert property ($rose(o_mem_req) && o_mem_we |->
        $past(free_read_r) != $past(free_write_r))
        else $error("write issued to a full free ring");
    no_end_slot_a: assert property ($rose(o_mem_req) && !o_mem_we |->
        o_mem_addr != ring_addr(queue_base_r, rdy_end_r))
        else $error("fetch aimed at the ready ring end slot");
    empty_fetch_a: assert property ($rose(o_mem_req) && !o_mem_we |-> !$past(rdy_empty))
        else $error("fetch from an empty ready ring");
    read_adv_a: assert property (fetch_ack |=>
        rdy_read_r == ring_next($past(rdy_read_r), rdy_start_r, rdy_end_r))
        else $error("ready read offset did not advance");
    uflow_set_a: assert property (i_uflow_valid |=> ctx_u[$past(uidx)])
        else $error("underflow flag not set");
    flush_done_a: assert property (flush_r && cache_cnt_r == 4'h1 && flush_ack |=> !flush_r)
        else $error("flush did not end when cache drained");

    full_flush_c: cover property (push && cache_cnt_r == 4'(CACHE_DEPTH - 1));
    ioc_flush_c: cover property (push && i_done_ioc ##[1:20] flush_ack);
    fetch_c: cover property (fetch_ack ##1 fetch_valid_r);
    sel_high_c: cover property (o_sel_valid && o_sel_hit && o_sel_pri);
endmodule

/* tdq_map.svh */
`ifndef TDQ_MAP_SVH
`define TDQ_MAP_SVH

// ==========================================================================
// Register offsets (byte addresses, one aligned word each)
`define TDQ_OFF_CTRL        12'h000
`define TDQ_OFF_STATUS      12'h004
`define TDQ_OFF_DESC_BASE   12'h008
`define TDQ_OFF_QUEUE_BASE  12'h00C
`define TDQ_OFF_RDY_START   12'h010
`define TDQ_OFF_RDY_WRITE   12'h014
`define TDQ_OFF_RDY_READ    12'h018
`define TDQ_OFF_RDY_END     12'h01C
`define TDQ_OFF_FREE_START  12'h020
`define TDQ_OFF_FREE_WRITE  12'h024
`define TDQ_OFF_FREE_READ   12'h028
`define TDQ_OFF_FREE_END    12'h02C
`define TDQ_CTX_WINDOW_BIT  10

// ==========================================================================
// Reset values
`define TDQ_RST_WORD        32'h0000_0000
`define TDQ_RST_OFF         16'h0000

// ==========================================================================
// Control fields
`define TDQ_CTRL_FETCH_EN   0
`define TDQ_CTRL_CACHE_EN   1

// ==========================================================================
// Returned reference status codes
`define TDQ_ST_LAST         2'h0
`define TDQ_ST_PARTIAL      2'h1
`define TDQ_ST_UNPROV       2'h2
`define TDQ_ST_MALFORMED    2'h3

// ==========================================================================
// Context word field positions
`define TDQ_CTX_D_BIT       14
`define TDQ_CTX_A_BIT       15
`define TDQ_CTX_V_BIT       14
`define TDQ_CTX_NA_BIT      17
`define TDQ_CTX_PIP_BIT     18
`define TDQ_CTX_U_BIT       16

`endif

/* tdq_pkg.sv */
package tdq_pkg;

    typedef logic [13:0] tdq_ref_t;
    typedef logic [4:0] tdq_ch_t;
    typedef logic [1:0] tdq_status_t;

    typedef enum logic [2:0]
    {
        TDQ_OP_NONE = 3'h0,
        TDQ_OP_LINK = 3'h1,
        TDQ_OP_SELECT = 3'h2,
        TDQ_OP_ACCESS = 3'h3,
        TDQ_OP_ADVANCE = 3'h4
    } tdq_op_t;

    typedef enum logic [2:0]
    {
        TDQ_ST_IDLE = 3'b001,
        TDQ_ST_FETCH = 3'b010,
        TDQ_ST_FLUSH = 3'b100
    } tdq_state_t;

endpackage

/* tdq_host_mem.sv */
`timescale 1ns/1ns

// ==========================================================================
// Host memory model: answers every request after a few cycles.
module tdq_host_mem (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_req,
    input wire logic i_we,
    input wire logic [31:0] i_addr,
    input wire logic [31:0] i_wdata,
    output logic o_ack,
    output logic [31:0] o_rdata,
    output int o_writes
);
    logic [31:0] mem [0:63];
    logic [1:0] wait_r;
    logic hit;
    assign hit = i_req && !o_ack && (wait_r == 2'h2);
    always @(posedge i_clock or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wait_r <= 2'h0;
            o_ack <= 1'b0;
            o_rdata <= 32'hA5A5_A5A5;
            o_writes <= 0;
        end
        else
        begin
            wait_r <= (i_req && !o_ack && !hit) ? wait_r + 2'h1 : 2'h0;
            o_ack <= hit;
            // Read data outside an answer is scrambled so stale values cannot pass.
            o_rdata <= (hit && !i_we) ? mem[i_addr[7:2]] : ~o_rdata;
            if (hit && i_we)
            begin
                mem[i_addr[7:2]] <= i_wdata;
                o_writes <= o_writes + 1;
            end
        end
    end
endmodule

/* tdq_queue_mgr_tb_top.sv */
`timescale 1ns/1ns
`include "tdq_map.svh"

// ==========================================================================
// Testbench top.
module tdq_queue_mgr_tb_top;
    import tdq_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, fr = 1'b0, uv = 1'b0, dv = 1'b0;
    logic completion_irq_flag = 1'b0, mreq, mwe, mack, fv, drdy;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h0, rdata, maddr, mwdata, mrdata, faddr, got;
    logic pri = 1'b0, sv, sh, sp, ad;
    tdq_op_t op = TDQ_OP_NONE;
    tdq_ch_t ch = 5'h1;
    tdq_ref_t cref = 14'h0, sref;
    logic [15:0] cbytes = 16'h0;
    logic [31:0] cbuf = 32'h0, saddr;
    tdq_ref_t fref, dref = 14'h0;
    tdq_status_t dst = 2'h0;
    int writes, bad_count = 0, total_checks = 0;
    tdq_queue_mgr u_tdq_queue_mgr (.i_clock(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_mem_req(mreq), .o_mem_we(mwe),
        .o_mem_addr(maddr), .o_mem_wdata(mwdata), .i_mem_ack(mack), .i_mem_rdata(mrdata),
        .o_fetch_valid(fv), .o_fetch_ref(fref), .o_fetch_addr(faddr), .i_fetch_ready(fr),
        .i_ctx_op(op), .i_ctx_ch(ch), .i_ctx_pri(pri), .i_ctx_ref(cref),
        .i_ctx_host(14'h0), .i_ctx_m(1'b0), .i_ctx_ce(1'b0), .i_ctx_abrt(1'b0), .i_ctx_ioc(1'b0),
        .i_ctx_bytes(cbytes), .i_ctx_buf_addr(cbuf), .o_sel_valid(sv), .o_sel_hit(sh),
        .o_sel_pri(sp), .o_sel_ref(sref), .o_sel_addr(saddr), .o_acc_done(ad),
        .i_uflow_valid(uv), .i_uflow_ch(ch), .i_uflow_pri(pri), .i_done_valid(dv),
        .o_done_ready(drdy), .i_done_ch(ch), .i_done_pri(pri), .i_done_ref(dref),
        .i_done_status(dst), .i_done_ioc(completion_irq_flag));
    tdq_host_mem u_tdq_host_mem (.i_clock(clk), .i_rst_n(rst_n), .i_req(mreq), .i_we(mwe),
        .i_addr(maddr), .i_wdata(mwdata), .o_ack(mack), .o_rdata(mrdata), .o_writes(writes));

    initial forever #20 clk = ~clk;

    task automatic check(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rreg(input logic [11:0] a);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 got = rdata;
        @(posedge clk);
    endtask
    task automatic push(input tdq_ref_t r, input tdq_status_t s, input logic i);
        dref <= r;
        dst <= s;
        completion_irq_flag <= i;
        dv <= 1'b1;
        @(posedge clk);
        while (!drdy) @(posedge clk);
        dv <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ctx(input tdq_op_t o);
        op <= o;
        @(posedge clk);
        op <= TDQ_OP_NONE;
        #1 got = {14'h0, sv, sh, sp, ad, sref};
        @(posedge clk);
    endtask
    task automatic t_ctx;
        ch <= 5'h3;
        pri <= 1'b1;
        cref <= 14'h7;
        cbytes <= 16'h2;
        cbuf <= 32'h100;
        ctx(TDQ_OP_LINK);
        ctx(TDQ_OP_SELECT);
        check(got, 32'h0003_8007);
        check(saddr, 32'h2000_0070);
        ctx(TDQ_OP_ACCESS);
        check(got, 32'h0001_8007);
        ctx(TDQ_OP_ACCESS);
        check(got, 32'h0001_C007);
        ch <= 5'h4;
        pri <= 1'b0;
        cref <= 14'h9;
        ctx(TDQ_OP_LINK);
        ctx(TDQ_OP_SELECT);
        check(got, 32'h0003_0009);
        $display("context test done");
    endtask
    task automatic t_fetch;
        rreg(12'h030);
        check(got, 32'h0);
        u_tdq_host_mem.mem[1] = 32'h0000_0005;
        wreg(`TDQ_OFF_DESC_BASE, 32'h2000_0000);
        wreg(`TDQ_OFF_RDY_END, 32'h8);
        wreg(`TDQ_OFF_RDY_WRITE, 32'h2);
        wreg(`TDQ_OFF_CTRL, 32'h1);
        repeat (50) if (!fv) @(posedge clk);
        check(32'(fref), 32'h5);
        check(faddr, 32'h2000_0050);
        fr <= 1'b1;
        @(posedge clk);
        fr <= 1'b0;
        rreg(`TDQ_OFF_RDY_READ);
        check(got, 32'h1);
        $display("fetch test done");
    endtask
    task automatic t_free;
        wreg(`TDQ_OFF_FREE_START, 32'h10);
        wreg(`TDQ_OFF_FREE_WRITE, 32'h10);
        wreg(`TDQ_OFF_FREE_READ, 32'h17);
        wreg(`TDQ_OFF_FREE_END, 32'h18);
        wreg(`TDQ_OFF_CTRL, 32'h3);
        uv <= 1'b1;
        @(posedge clk);
        uv <= 1'b0;
        push(14'h3, `TDQ_ST_UNPROV, 1'b1);
        repeat (50) if (writes < 1) @(posedge clk);
        check(u_tdq_host_mem.mem[16], 32'h0001_8003);
        for (int i = 0; i < 6; i++)
        begin
            if (i == 5) check(writes, 1);
            push(tdq_ref_t'(i), `TDQ_ST_PARTIAL, 1'b0);
        end
        repeat (200) if (writes < 7) @(posedge clk);
        check(u_tdq_host_mem.mem[17], 32'h0000_4000);
        check(u_tdq_host_mem.mem[22], 32'h0000_4005);
        rreg(`TDQ_OFF_FREE_WRITE);
        check(got, 32'h17);
        push(14'h9, `TDQ_ST_LAST, 1'b1);
        repeat (20) @(posedge clk);
        check(writes, 7);
        $display("free ring test done");
    endtask
    task automatic report_and_stop;
        $display("checks=%0d mismatches=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_fetch();
        t_free();
        t_ctx();
        report_and_stop();
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
endmodule
